// *** rtl/core_interrupt_controller.sv ***
// core interrupt controller: latching, masking, priority, vectors, wake-up
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1: maskable requests serviced only when mask clear
// RULE2: masked requests stay latched until enabled
// RULE3: mask bit set out of reset
// RULE4: entry stacks context, sets mask, loads vector
// RULE5: return restores context, mask cleared
// RULE6: handler not preempted while mask set
// RULE7: fixed priority reset, trap, source 0..13
// RULE8: two-byte vectors descending from top
// RULE9: any source wakes from wait
// RULE10: trap taken regardless of mask
// RULE11: external vector needs event and clear mask
// RULE12: edge request latched, cleared on entry
// RULE13: low nand input masks combined request
// RULE14: peripheral needs mask clear and enable
// RULE15: clear sequence drops the latched request
// RULE16: sense codes fall+low, rise, fall, both
// RULE17: low sense register holds lines 0..2
// RULE18: high sense register holds lines 3..4
// RULE19: sense writes only while mask set
// RULE20: sense change clears that line's pending
// RULE21: line 2 falling edge never wakes halt
// RULE22: line 4 wakes only wait, active-halt
// RULE23: halt wake-up depends on source
// RULE24: reserved sense bits read zero
module core_interrupt_controller #(
  parameter int PERIPH_N = 14
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [4:0]           ext_line_pin,
  input  wire logic                 ext_nand_gate_n,
  input  wire logic [PERIPH_N-1:0]  periph_event,
  input  wire logic [PERIPH_N-1:0]  periph_clear,
  input  wire logic                 instr_boundary,
  input  wire logic                 trap_exec,
  input  wire logic                 return_from_interrupt,
  input  wire logic [1:0]           lp_mode,
  input  wire logic                 halt_auto_wakeup,
  output logic                      irq_take,
  output logic      [15:0]          irq_vector,
  output logic                      stack_push,
  output logic                      stack_pop,
  output logic                      wake_up,
  output logic                      mask_bit
);

  // synchronised pins: first stage read only by second
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_prev_q;
  logic       nand_s1_q;
  logic       nand_s2_q;
  logic [7:0] sense_low_q;
  logic [7:0] sense_high_q;
  logic [PERIPH_N-1:0] periph_en_q;
  logic [PERIPH_N-1:0] periph_flag_q;
  logic [4:0] ext_pend_q;
  logic       mask_q;
  logic [4:0] ext_event;
  logic [4:0] ext_level;
  logic [4:0] sense_chg;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] req;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] wake_halt;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] win;
  logic       any_req;
  logic       take;
  logic       serve_ext;
  logic [3:0] win_idx;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] lo_new;
  logic [7:0] hi_new;
  logic [1:0] mode;

  assign mode = lp_mode;

  // sense field of line n
  function automatic logic [1:0] field(input logic [7:0] lo, input logic [7:0] hi,
                                        input int n);
    case (n)
      0:       field = lo[irq_ctrl_pkg::LINE0_POS +: 2];
      1:       field = lo[irq_ctrl_pkg::LINE1_POS +: 2];
      2:       field = lo[irq_ctrl_pkg::LINE2_POS +: 2];
      3:       field = hi[irq_ctrl_pkg::LINE3_POS +: 2];
      default: field = hi[irq_ctrl_pkg::LINE4_POS +: 2];
    endcase
  endfunction

  // map external line index to source number
  function automatic int ext_src(input int n);
    case (n)
      0:       ext_src = irq_ctrl_pkg::SRC_EXT0;
      1:       ext_src = irq_ctrl_pkg::SRC_EXT1;
      2:       ext_src = irq_ctrl_pkg::SRC_EXT2;
      3:       ext_src = irq_ctrl_pkg::SRC_EXT3;
      default: ext_src = irq_ctrl_pkg::SRC_EXT4;
    endcase
  endfunction

  // two-flop synchroniser for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle-high reset so the first synced high is no false rising edge
      pin_s1_q   <= 5'h1F;
      pin_s2_q   <= 5'h1F;
      pin_prev_q <= 5'h1F;
      nand_s1_q  <= 1'b1;
      nand_s2_q  <= 1'b1;
    end else begin
      pin_s1_q   <= ext_line_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      nand_s1_q  <= ext_nand_gate_n;
      nand_s2_q  <= nand_s1_q;
    end
  end

  // apb access strobes; slave always answers in the access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // new sense values, reserved bits forced to zero
  assign lo_new = {2'h0, pwdata[5:0]}; // RULE17 RULE24
  assign hi_new = {4'h0, pwdata[3:0]}; // RULE18 RULE24

  // edge/level detection per line, with nand gating on line 0
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      logic rise;
      logic fall;
      rise = pin_s2_q[n] && !pin_prev_q[n];
      fall = !pin_s2_q[n] && pin_prev_q[n];
      ext_level[n] = 1'b0;
      unique case (field(sense_low_q, sense_high_q, n)) // RULE16
        irq_ctrl_pkg::SENSE_FALL_LOW: begin
          ext_event[n] = fall;
          ext_level[n] = !pin_s2_q[n];
        end
        irq_ctrl_pkg::SENSE_RISE: ext_event[n] = rise;
        irq_ctrl_pkg::SENSE_FALL: ext_event[n] = fall;
        irq_ctrl_pkg::SENSE_BOTH: ext_event[n] = rise || fall;
      endcase
      sense_chg[n] = wr_acc && mask_q && (n < 3 ?
        (paddr == irq_ctrl_pkg::SENSE_LOW_OFS &&
         field(lo_new, sense_high_q, n) != field(sense_low_q, sense_high_q, n)) :
        (paddr == irq_ctrl_pkg::SENSE_HIGH_OFS &&
         field(sense_low_q, hi_new, n) != field(sense_low_q, sense_high_q, n)));
    end
    // a low on the combined input masks line 0 even for rising sense
    if (!nand_s2_q) begin // RULE13
      ext_event[0] = 1'b0;
      ext_level[0] = 1'b0;
    end
  end

  // sense registers writable only while masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_low_q  <= irq_ctrl_pkg::SENSE_RESET;
      sense_high_q <= irq_ctrl_pkg::SENSE_RESET; // RULE18
    end else if (wr_acc && mask_q) begin // RULE19
      if (paddr == irq_ctrl_pkg::SENSE_LOW_OFS) sense_low_q <= lo_new;
      if (paddr == irq_ctrl_pkg::SENSE_HIGH_OFS) sense_high_q <= hi_new;
    end
  end

  // external pending latches; set wins over entry clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pend_q <= 5'h00;
    end else begin
      for (int n = 0; n < 5; n++) begin
        if (sense_chg[n]) ext_pend_q[n] <= 1'b0; // RULE20
        // a falling edge served at once through its own low level is not latched again
        else if (ext_event[n] && !(serve_ext && win_idx == 4'(ext_src(n)) && ext_level[n]))
          ext_pend_q[n] <= 1'b1; // RULE2 RULE12
        else if (serve_ext && win_idx == 4'(ext_src(n))) ext_pend_q[n] <= 1'b0; // RULE12
      end
    end
  end

  // peripheral flags and enables; clear drops a pending request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flag_q <= '0;
      periph_en_q   <= '0;
    end else begin
      for (int i = 0; i < PERIPH_N; i++) begin
        if (periph_event[i]) periph_flag_q[i] <= 1'b1; // RULE14
        else if (periph_clear[i]) periph_flag_q[i] <= 1'b0; // RULE15
        else if (wr_acc && paddr == irq_ctrl_pkg::PERIPH_FLAG_OFS && !pwdata[i])
          periph_flag_q[i] <= 1'b0; // RULE15
      end
      if (wr_acc && paddr == irq_ctrl_pkg::PERIPH_EN_OFS)
        periph_en_q <= pwdata[PERIPH_N-1:0];
    end
  end

  // request vector: peripherals need enable, external lines map over
  always_comb begin
    req = periph_flag_q & periph_en_q; // RULE14
    wake_halt = '0;
    for (int n = 0; n < 5; n++) begin
      req[ext_src(n)] = ext_pend_q[n] || ext_level[n]; // RULE11
      wake_halt[ext_src(n)] = ext_event[n] || ext_level[n];
    end
    // line 2 falling edge never wakes halt variants
    if (!pin_s2_q[2]) wake_halt[irq_ctrl_pkg::SRC_EXT2] = 1'b0; // RULE21
    // line 4 only from active-halt
    wake_halt[irq_ctrl_pkg::SRC_EXT4] = wake_halt[irq_ctrl_pkg::SRC_EXT4] &&
      mode == irq_ctrl_pkg::MODE_ACTIVE_HALT; // RULE22
    wake_halt[irq_ctrl_pkg::SRC_AWU] = req[irq_ctrl_pkg::SRC_AWU] &&
      mode == irq_ctrl_pkg::MODE_HALT && halt_auto_wakeup; // RULE23
    wake_halt[irq_ctrl_pkg::SRC_ATOVF] = req[irq_ctrl_pkg::SRC_ATOVF] &&
      mode == irq_ctrl_pkg::MODE_ACTIVE_HALT; // RULE23
    wake_halt[irq_ctrl_pkg::SRC_RTC] = req[irq_ctrl_pkg::SRC_RTC] &&
      mode == irq_ctrl_pkg::MODE_ACTIVE_HALT; // RULE23
  end

  // fixed priority: lowest source number wins
  always_comb begin
    win = req & ~(req - 14'h0001); // RULE7
    win_idx = 4'h0;
    for (int s = irq_ctrl_pkg::NUM_SRC - 1; s >= 0; s--)
      if (req[s]) win_idx = 4'(s);
  end
  assign any_req = |win;
  // trap ignores the mask, maskable ones need it clear
  assign take = instr_boundary && (trap_exec || (any_req && !mask_q)); // RULE1 RULE6 RULE10
  // a trap entry must not consume a pending external request
  assign serve_ext = take && !trap_exec;

  // global mask: set on reset and on entry, cleared by return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= irq_ctrl_pkg::MASK_RESET; // RULE3
    end else if (take) begin
      mask_q <= 1'b1; // RULE4 RULE6
    end else if (return_from_interrupt) begin
      mask_q <= 1'b0; // RULE5
    end else if (wr_acc && paddr == irq_ctrl_pkg::CORE_CTRL_OFS) begin
      mask_q <= pwdata[0];
    end
  end

  // entry / return handshake to the core, vector from priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_take   <= 1'b0;
      irq_vector <= irq_ctrl_pkg::VEC_RESET; // RULE8
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
    end else begin
      irq_take   <= take;
      stack_push <= take; // RULE4
      stack_pop  <= return_from_interrupt; // RULE5
      if (take) begin
        if (trap_exec) irq_vector <= irq_ctrl_pkg::VEC_TRAP; // RULE7 RULE8
        else irq_vector <= irq_ctrl_pkg::VEC_SRC0 - {11'h000, win_idx, 1'b0}; // RULE8
      end
    end
  end

  // wake request: any source in wait, selected ones in halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_up <= 1'b0;
    end else begin
      unique case (mode)
        irq_ctrl_pkg::MODE_RUN:  wake_up <= 1'b0;
        irq_ctrl_pkg::MODE_WAIT: wake_up <= |req; // RULE9
        default:                 wake_up <= |wake_halt; // RULE11 RULE23
      endcase
    end
  end

  // apb read mux; unmapped reads zero, no error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      mask_bit <= irq_ctrl_pkg::MASK_RESET;
    end else begin
      pready   <= psel && !penable;
      pslverr  <= 1'b0;
      mask_bit <= mask_q;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          irq_ctrl_pkg::SENSE_LOW_OFS:   prdata <= {24'h0, sense_low_q};
          irq_ctrl_pkg::SENSE_HIGH_OFS:  prdata <= {24'h0, sense_high_q};
          irq_ctrl_pkg::CORE_CTRL_OFS:   prdata <= {31'h0, mask_q};
          irq_ctrl_pkg::PERIPH_EN_OFS:   prdata <= 32'(periph_en_q);
          irq_ctrl_pkg::PERIPH_FLAG_OFS: prdata <= 32'(periph_flag_q);
          irq_ctrl_pkg::PENDING_OFS:     prdata <= {27'h0, ext_pend_q};
          irq_ctrl_pkg::STATUS_OFS:      prdata <= {18'h0, req};
          default:                       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // mask must be set on the cycle after any entry
  chk_entry_sets_mask: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> mask_q) else $error("mask not set after entry"); // RULE4
  // no maskable entry while masked
  chk_masked_no_take: assert property (@(posedge pclk) disable iff (!presetn)
    (take && !trap_exec) |-> !mask_q) else $error("entry while masked"); // RULE1
  // trap entry vector
  chk_trap_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (take && trap_exec) |=> irq_vector == irq_ctrl_pkg::VEC_TRAP)
    else $error("wrong trap vector"); // RULE10
  // return clears the mask
  chk_return_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (return_from_interrupt && !take) |=> !mask_q) else $error("mask kept"); // RULE5
  // sense writes blocked while unmasked
  chk_sense_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (!mask_q && wr_acc) |=> $stable(sense_low_q) && $stable(sense_high_q))
    else $error("sense written unmasked"); // RULE19
  // reserved bits stay zero
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    sense_low_q[7:6] == 2'h0 && sense_high_q[7:4] == 4'h0)
    else $error("reserved bit set"); // RULE24
  // sense change drops pending
  chk_change_clears: assert property (@(posedge pclk) disable iff (!presetn)
    sense_chg[2] |=> !ext_pend_q[2]) else $error("pending survived change"); // RULE20
  // masked pending stays latched
  chk_pending_held: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_pend_q[1] && mask_q && !sense_chg[1]) |=> ext_pend_q[1])
    else $error("pending lost"); // RULE2
  // trap entered at any boundary, masked or not
  chk_trap_entry: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (instr_boundary && trap_exec) |=> irq_take && irq_vector == irq_ctrl_pkg::VEC_TRAP)
    else $error("trap not entered");
  // push accompanies every entry
  chk_push_with_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    irq_take == stack_push) else $error("push without entry");
  // pop follows every return
  chk_pop_after_ret: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    return_from_interrupt |=> stack_pop) else $error("no pop after return");
  // any request wakes from wait
  chk_wait_wakes: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (mode == irq_ctrl_pkg::MODE_WAIT && |req) |=> wake_up) else $error("no wait wake");
  // line 2 low never counts for halt wake
  chk_line2_no_wake: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    !pin_s2_q[2] |-> !wake_halt[irq_ctrl_pkg::SRC_EXT2]) else $error("line 2 woke halt");
  // line 4 never wakes plain halt
  chk_line4_no_halt: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    mode == irq_ctrl_pkg::MODE_HALT |-> !wake_halt[irq_ctrl_pkg::SRC_EXT4])
    else $error("line 4 woke halt");
  // combined input low hides line 0
  chk_nand_masks: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    !nand_s2_q |-> !ext_event[0] && !ext_level[0]) else $error("nand not masking");
  // disabled peripheral raises nothing
  chk_periph_enable: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    !periph_en_q[irq_ctrl_pkg::SRC_RTC] |-> !req[irq_ctrl_pkg::SRC_RTC])
    else $error("disabled source requests");
  // clear sequence drops the flag
  chk_clear_drops: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (periph_clear[irq_ctrl_pkg::SRC_RTC] && !periph_event[irq_ctrl_pkg::SRC_RTC])
    |=> !periph_flag_q[irq_ctrl_pkg::SRC_RTC]) else $error("flag survived clear");
  // entry clears the served edge latch
  chk_entry_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (serve_ext && win_idx == 4'(irq_ctrl_pkg::SRC_EXT1) && !ext_event[1])
    |=> !ext_pend_q[1]) else $error("edge latch kept");
endmodule
`default_nettype wire

// *** rtl/irq_ctrl_pkg.sv ***
// shared constants for the core interrupt controller
package irq_ctrl_pkg;
  // apb register byte offsets
  localparam logic [11:0] SENSE_LOW_OFS   = 12'h000;
  localparam logic [11:0] SENSE_HIGH_OFS  = 12'h004;
  localparam logic [11:0] CORE_CTRL_OFS   = 12'h008;
  localparam logic [11:0] PERIPH_EN_OFS   = 12'h00C;
  localparam logic [11:0] PERIPH_FLAG_OFS = 12'h010;
  localparam logic [11:0] PENDING_OFS     = 12'h014;
  localparam logic [11:0] STATUS_OFS      = 12'h018;
  // reset values
  localparam logic [7:0]  SENSE_RESET     = 8'h00;
  localparam logic        MASK_RESET      = 1'b1;
  // sensitivity field codes
  localparam logic [1:0]  SENSE_FALL_LOW  = 2'h0;
  localparam logic [1:0]  SENSE_RISE      = 2'h1;
  localparam logic [1:0]  SENSE_FALL      = 2'h2;
  localparam logic [1:0]  SENSE_BOTH      = 2'h3;
  // field positions in the sense registers
  localparam int          LINE0_POS       = 0;
  localparam int          LINE1_POS       = 2;
  localparam int          LINE2_POS       = 4;
  localparam int          LINE3_POS       = 0;
  localparam int          LINE4_POS       = 2;
  // source numbers
  localparam int          NUM_SRC         = 14;
  localparam int          SRC_AWU         = 0;
  localparam int          SRC_EXT0        = 1;
  localparam int          SRC_EXT1        = 2;
  localparam int          SRC_EXT2        = 3;
  localparam int          SRC_EXT3        = 5;
  localparam int          SRC_EXT4        = 6;
  localparam int          SRC_ATOVF       = 9;
  localparam int          SRC_RTC         = 11;
  // vectors
  localparam logic [15:0] VEC_RESET       = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP        = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0        = 16'hFFFA;
  // low-power modes of the core
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_ACTIVE_HALT, MODE_HALT} lp_mode_t;
  // encoding of halt sub-mode bit: 0 plain halt, 1 auto-wakeup halt
  localparam logic        HALT_PLAIN      = 1'b0;
endpackage

// *** verif/core_model.sv ***
// behavioural cpu core facing the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic irq_take,
  output logic      instr_boundary,
  output logic      return_from_interrupt
);
  logic [3:0] run_q;

  // instructions end each cycle, or at random when slow to stretch entry latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_boundary <= 1'h0;
    end else begin
      instr_boundary <= slow ? 1'($urandom_range(1)) : 1'h1;
    end
  end

  // handler runs eight cycles then returns; nesting is not modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q                 <= 4'h0;
      return_from_interrupt <= 1'h0;
    end else begin
      return_from_interrupt <= (run_q == 4'h1);
      if (irq_take) begin
        run_q <= 4'h8;
      end else if (run_q != 4'h0) begin
        run_q <= run_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the core interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, d;
  logic [4:0]  pins;
  logic [13:0] ev, clr, flags;
  logic        nand_n, bound, trap, ret, awu_halt, slow;
  logic        irq_take, stack_push, wake_up, mask_bit, got;
  logic [1:0]  lp_mode;
  logic [15:0] irq_vector, vec;
  int          error_cnt, checks;

  core_interrupt_controller dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_line_pin(pins), .ext_nand_gate_n(nand_n),
    .periph_event(ev), .periph_clear(clr), .instr_boundary(bound), .trap_exec(trap),
    .return_from_interrupt(ret), .lp_mode, .halt_auto_wakeup(awu_halt), .irq_take,
    .irq_vector, .stack_push, .stack_pop(), .wake_up, .mask_bit);
  core_model partner (.pclk, .presetn, .slow, .irq_take, .instr_boundary(bound),
    .return_from_interrupt(ret));

  always #25 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      error_cnt++;
      results();
    end
    chk("pslverr", pslverr, 1'h0);
    rdata = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic ctrl(input logic m);
    apb(1'h1, irq_ctrl_pkg::CORE_CTRL_OFS, {31'h0, m});
  endtask

  task automatic pulse_ev(input logic [13:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 14'h0;
  endtask

  // waits a bounded span for irq_take (sel 0) or wake_up (sel 1)
  task automatic watch(input logic sel, input int lim);
    int n;
    n = 0;
    got = 1'h0;
    while (!got && n < lim) begin
      @(posedge pclk);
      n++;
      got = ((sel ? wake_up : irq_take) === 1'h1);
    end
    vec = irq_vector;
  endtask

  // expects an entry, then clears the flag as a handler would
  task automatic serve(input logic [13:0] c);
    logic [15:0] v;
    watch(1'h0, 60);
    v = vec;
    chk("take", got, 1'h1);
    chk("push", stack_push, 1'h1);
    clr <= c;
    @(posedge pclk);
    clr <= 14'h0;
    chk("mask_entry", mask_bit, 1'h1);
    watch(1'h0, 4);
    chk("preempt", got, 1'h0);
    vec = v;
  endtask

  function automatic logic [15:0] vof(input int n);
    return 16'hFFFA - 16'(2 * n);
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ev, clr, trap, lp_mode, awu_halt, slow} = '0;
    pins = 5'h1F;
    nand_n = 1'h1;
    error_cnt = 0;
    checks = 0;
    void'($urandom(88));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("mask_reset", mask_bit, 1'h1);
    chk("vector_reset", irq_vector, 16'hFFFE);
    apb(1'h0, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'h0);
    chk("sense_high_reset", rdata, 32'h0);
    // random and all-ones fields; reserved bits must stay clear
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1'h1, irq_ctrl_pkg::SENSE_LOW_OFS, d);
      apb(1'h0, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h0);
      chk("sense_low", rdata, d & 32'h3F);
      apb(1'h1, irq_ctrl_pkg::SENSE_HIGH_OFS, d);
      apb(1'h0, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'h0);
      chk("sense_high", rdata, d & 32'h0F);
    end
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", rdata, 32'h0);
    apb(1'h1, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h0);
    apb(1'h1, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'h0);
    ctrl(1'h0);
    apb(1'h1, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h15);
    apb(1'h0, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h0);
    chk("sense_locked", rdata, 32'h0);
    $display("test registers done");
    // requests latched while masked, then served in priority order
    slow <= 1'h1;
    ctrl(1'h1);
    apb(1'h1, irq_ctrl_pkg::PERIPH_EN_OFS, 32'h3FFF);
    flags = 14'($urandom) & 14'h0F81 | 14'h0101;
    pulse_ev(flags);
    ctrl(1'h0);
    for (int k = 0; k < 14; k++) begin
      if (flags[k]) begin
        serve(14'h1 << k);
        chk("vector_prio", vec, vof(k));
      end
    end
    repeat (12) @(posedge pclk);
    chk("mask_return", mask_bit, 1'h0);
    apb(1'h1, irq_ctrl_pkg::PERIPH_EN_OFS, 32'h0);
    pulse_ev(14'h0100);
    watch(1'h0, 20);
    chk("disabled", got, 1'h0);
    apb(1'h1, irq_ctrl_pkg::PERIPH_FLAG_OFS, 32'h0);
    apb(1'h1, irq_ctrl_pkg::PERIPH_EN_OFS, 32'h100);
    watch(1'h0, 20);
    chk("flag_cleared", got, 1'h0);
    $display("test peripherals done");
    slow <= 1'h0;
    ctrl(1'h1);
    trap <= 1'h1;
    @(posedge pclk);
    trap <= 1'h0;
    serve(14'h0);
    chk("vector_trap", vec, 16'hFFFC);
    repeat (12) @(posedge pclk);
    // rising edges on lines 0 and 1 while the combined input is low
    ctrl(1'h1);
    apb(1'h1, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h05);
    pins <= 5'h1C;
    nand_n <= 1'h0;
    repeat (4) @(posedge pclk);
    pins <= 5'h1F;
    repeat (4) @(posedge pclk);
    ctrl(1'h0);
    watch(1'h0, 20);
    chk("vector_ext", vec, vof(irq_ctrl_pkg::SRC_EXT1));
    repeat (12) @(posedge pclk);
    watch(1'h0, 20);
    chk("edge_cleared", got, 1'h0);
    // every sensitivity code on line 3: a fall, then a rise
    for (int c = 0; c < 4; c++) begin
      ctrl(1'h1);
      apb(1'h1, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'(c));
      ctrl(1'h0);
      pins[3] <= 1'h0;
      watch(1'h0, 20);
      chk("fall", got, c != 1);
      if (c != 1) chk("vector_l3", vec, vof(irq_ctrl_pkg::SRC_EXT3));
      pins[3] <= 1'h1;
      watch(1'h0, 30);
      chk("rise", got, c % 2);
      repeat (12) @(posedge pclk);
    end
    ctrl(1'h1);
    apb(1'h1, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'h1);
    pins[3] <= 1'h0;
    repeat (4) @(posedge pclk);
    pins[3] <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h1, irq_ctrl_pkg::SENSE_HIGH_OFS, 32'h3);
    ctrl(1'h0);
    watch(1'h0, 20);
    chk("sense_change", got, 1'h0);
    $display("test external lines done");
    // wake-up from wait and plain halt, masked throughout
    ctrl(1'h1);
    apb(1'h1, irq_ctrl_pkg::PERIPH_EN_OFS, 32'h101);
    lp_mode <= 2'h1;
    pulse_ev(14'h100);
    watch(1'h1, 8);
    chk("wake_wait", got, 1'h1);
    apb(1'h1, irq_ctrl_pkg::PERIPH_FLAG_OFS, 32'h0);
    lp_mode <= 2'h3;
    pulse_ev(14'h100);
    watch(1'h1, 8);
    chk("wake_halt_periph", got, 1'h0);
    apb(1'h1, irq_ctrl_pkg::SENSE_LOW_OFS, 32'h28);
    pins[2] <= 1'h0;
    watch(1'h1, 8);
    chk("wake_line2_fall", got, 1'h0);
    pins[1] <= 1'h0;
    watch(1'h1, 8);
    chk("wake_line1", got, 1'h1);
    lp_mode <= 2'h0;
    $display("test wake-up done");
    results();
  end
endmodule
`default_nettype wire
